// File: hw/bmx_pkg.sv
// Shared constants and types of the bit manipulation execute unit.
// Assumes an 8-bit core with 16-bit program counter and a flag byte.
package bmx_pkg;

    // ------------------------------------------------------------
    // Opcodes and second-byte fields
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_BIT_SET_CLR = 8'h77;
    localparam logic [7:0] OPC_BIT_OR = 8'h07;
    localparam logic [7:0] OPC_BIT_TEST = 8'h37;
    localparam int B2_REG_MSB = 7;
    localparam int B2_REG_LSB = 4;
    localparam int B2_BIT_MSB = 3;
    localparam int B2_BIT_LSB = 1;
    localparam int B2_SEL = 0;
    localparam logic [3:0] WREG_PAD = 4'h0;

    // ------------------------------------------------------------
    // Lengths in bytes and cycles per instruction
    // ------------------------------------------------------------
    localparam logic [1:0] LEN_BIT_SET_CLR = 2'h2;
    localparam logic [1:0] LEN_BIT_OR = 2'h3;
    localparam logic [1:0] LEN_BIT_TEST = 2'h3;
    localparam logic [3:0] CYC_BIT_SET_CLR = 4'h4;
    localparam logic [3:0] CYC_BIT_OR = 4'h6;
    localparam logic [3:0] CYC_BIT_TEST = 4'ha;
    localparam logic [3:0] CYC_LEAD = 4'h2;
    localparam logic [3:0] CNT_LAST = 4'h1;

    // ------------------------------------------------------------
    // Flag byte positions
    // ------------------------------------------------------------
    localparam int FLG_C = 7;
    localparam int FLG_Z = 6;
    localparam int FLG_S = 5;
    localparam int FLG_V = 4;
    localparam int FLG_D = 3;
    localparam int FLG_H = 2;

    localparam int PC_W = 16;
    localparam int DISP_W = 8;

    // ------------------------------------------------------------
    // Decoded operation, one-hot
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        OP_NONE = 6'b00_0001,
        OP_BIT_SET = 6'b00_0010,
        OP_BIT_CLEAR = 6'b00_0100,
        OP_BIT_OR = 6'b00_1000,
        OP_JUMP_ZERO = 6'b01_0000,
        OP_JUMP_ONE = 6'b10_0000
    } bmx_op_t;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_WAIT = 3'b100
    } bmx_state_t;

endpackage : bmx_pkg

// File: hw/bmx_dec_if.sv
// Carrier between the sequencer and the opcode decoder.
// Assumes the decoder is purely combinational.
`timescale 1ns/1ps
interface bmx_dec_if;
    logic [7:0] opcode;
    logic [7:0] byte2;
    bmx_pkg::bmx_op_t op;
    logic [3:0] wreg;
    logic [2:0] bit_idx;
    logic [3:0] cycles;
    logic [1:0] bytes;

    modport dec (
        input opcode,
        input byte2,
        output op,
        output wreg,
        output bit_idx,
        output cycles,
        output bytes
    );

    modport core (
        output opcode,
        output byte2,
        input op,
        input wreg,
        input bit_idx,
        input cycles,
        input bytes
    );
endinterface : bmx_dec_if

// File: hw/bmx_decode.sv
// Opcode and second-byte decoder of the bit manipulation unit.
// Assumes the caller holds opcode and second byte stable while it reads.
`timescale 1ns/1ps
module bmx_decode (
    bmx_dec_if.dec dif
);

    // ------------------------------------------------------------
    // Field split and operation select
    // ------------------------------------------------------------

    // Register and bit fields are common to all three formats
    assign dif.wreg = dif.byte2[bmx_pkg::B2_REG_MSB:bmx_pkg::B2_REG_LSB];
    assign dif.bit_idx = dif.byte2[bmx_pkg::B2_BIT_MSB:bmx_pkg::B2_BIT_LSB];

    // Select bit picks set/clear and the two jump senses
    always_comb begin
        dif.op = bmx_pkg::OP_NONE;
        dif.cycles = bmx_pkg::CYC_BIT_SET_CLR;
        dif.bytes = bmx_pkg::LEN_BIT_SET_CLR;
        unique case (dif.opcode)
            bmx_pkg::OPC_BIT_SET_CLR: begin
                dif.cycles = bmx_pkg::CYC_BIT_SET_CLR;
                dif.bytes = bmx_pkg::LEN_BIT_SET_CLR;
                if (dif.byte2[bmx_pkg::B2_SEL]) begin
                    dif.op = bmx_pkg::OP_BIT_SET;
                end else begin
                    dif.op = bmx_pkg::OP_BIT_CLEAR;
                end
            end
            bmx_pkg::OPC_BIT_OR: begin
                dif.op = bmx_pkg::OP_BIT_OR;
                dif.cycles = bmx_pkg::CYC_BIT_OR;
                dif.bytes = bmx_pkg::LEN_BIT_OR;
            end
            bmx_pkg::OPC_BIT_TEST: begin
                dif.cycles = bmx_pkg::CYC_BIT_TEST;
                dif.bytes = bmx_pkg::LEN_BIT_TEST;
                if (dif.byte2[bmx_pkg::B2_SEL]) begin
                    dif.op = bmx_pkg::OP_JUMP_ONE;
                end else begin
                    dif.op = bmx_pkg::OP_JUMP_ZERO;
                end
            end
            default: begin
                dif.op = bmx_pkg::OP_NONE;
            end
        endcase
    end

endmodule : bmx_decode

// File: hw/bmx_exec.sv
// Execute unit for bit set/clear, bit OR and bit-test relative jumps.
// Assumes a register file that answers a read address in the same cycle
// and a core that applies the write, flag and PC strobes it is given.
//
// Summary of operation
// - Bit set writes one, keeps other bits
// - Bit set and bit jumps keep flags
// - Bit set: 77h, two bytes, four cycles
// - Bit OR merges a bit, either direction
// - Bit OR: Z from result, S cleared
// - Bit OR: 07h, three bytes, six cycles
// - Jump adds displacement when tested bit equals select
// - Bit jump: 37h, three bytes, ten cycles
// - Displacement is signed eight bits
// - 77h with select zero clears the bit
// - 37h with select one jumps on one
`timescale 1ns/1ps
module bmx_exec (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic [7:0] opcode,
    input wire logic [7:0] byte2,
    input wire logic [7:0] byte3,
    input wire logic [15:0] pc_next,
    input wire logic [7:0] flags_in,
    input wire logic [7:0] wreg_rd_data,
    input wire logic [7:0] reg_rd_data,
    output logic busy_ff,
    output logic done_ff,
    output logic illegal_ff,
    output logic [3:0] wreg_rd_addr_ff,
    output logic [7:0] reg_rd_addr_ff,
    output logic wr_en_ff,
    output logic wr_working_ff,
    output logic [7:0] wr_addr_ff,
    output logic [7:0] wr_data_ff,
    output logic flag_we_ff,
    output logic [7:0] flags_out_ff,
    output logic pc_we_ff,
    output logic [15:0] pc_out_ff
);

    // ------------------------------------------------------------
    // Decoder
    // ------------------------------------------------------------
    bmx_dec_if dif ();

    // Decode straight from the ports; only used in the start cycle
    assign dif.opcode = opcode;
    assign dif.byte2 = byte2;

    bmx_decode u_decode (
        .dif(dif.dec)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    bmx_pkg::bmx_state_t state_ff, nxt_state;
    bmx_pkg::bmx_op_t op_ff, nxt_op;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [2:0] bit_ff, nxt_bit;
    logic sel_ff, nxt_sel;
    logic [7:0] disp_ff, nxt_disp;
    logic [15:0] pcn_ff, nxt_pcn;
    logic nxt_busy, nxt_done, nxt_illegal;
    logic [3:0] nxt_wreg_rd_addr;
    logic [7:0] nxt_reg_rd_addr;
    logic nxt_wr_en, nxt_wr_working;
    logic [7:0] nxt_wr_addr, nxt_wr_data;
    logic nxt_flag_we;
    logic [7:0] nxt_flags_out;
    logic nxt_pc_we;
    logic [15:0] nxt_pc_out;

    // Operand views, valid while in the read state
    logic [7:0] mask;
    logic src_bit;
    logic or_bit;
    logic tested;
    logic [15:0] disp_ext;

    assign mask = 8'h01 << bit_ff;
    assign tested = wreg_rd_data[bit_ff];
    // Sign-extend so a taken jump reaches +127 to -128
    assign disp_ext = {{(bmx_pkg::PC_W - bmx_pkg::DISP_W){disp_ff[7]}}, disp_ff};

    // Bit OR operand bits for both directions
    always_comb begin
        if (sel_ff) begin
            src_bit = wreg_rd_data[0];
            or_bit = reg_rd_data[bit_ff] | src_bit;
        end else begin
            src_bit = reg_rd_data[bit_ff];
            or_bit = wreg_rd_data[0] | src_bit;
        end
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------

    // Strobes are single pulses; only the idle state accepts work
    always_comb begin
        nxt_state = state_ff;
        nxt_op = op_ff;
        nxt_cnt = cnt_ff;
        nxt_bit = bit_ff;
        nxt_sel = sel_ff;
        nxt_disp = disp_ff;
        nxt_pcn = pcn_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_illegal = 1'b0;
        nxt_wreg_rd_addr = wreg_rd_addr_ff;
        nxt_reg_rd_addr = reg_rd_addr_ff;
        nxt_wr_en = 1'b0;
        nxt_wr_working = wr_working_ff;
        nxt_wr_addr = wr_addr_ff;
        nxt_wr_data = wr_data_ff;
        nxt_flag_we = 1'b0;
        nxt_flags_out = flags_out_ff;
        nxt_pc_we = 1'b0;
        nxt_pc_out = pc_out_ff;
        unique case (state_ff)
            bmx_pkg::ST_IDLE: begin
                if (start) begin
                    if (dif.op == bmx_pkg::OP_NONE) begin
                        // Unknown opcode: flag it and stay idle
                        nxt_illegal = 1'b1;
                    end else begin
                        nxt_state = bmx_pkg::ST_READ;
                        nxt_busy = 1'b1;
                        nxt_op = dif.op;
                        nxt_bit = dif.bit_idx;
                        nxt_sel = byte2[bmx_pkg::B2_SEL];
                        nxt_disp = byte3;
                        nxt_pcn = pc_next;
                        nxt_cnt = dif.cycles - bmx_pkg::CYC_LEAD;
                        nxt_wreg_rd_addr = dif.wreg;
                        nxt_reg_rd_addr = byte3;
                    end
                end
            end
            bmx_pkg::ST_READ: begin
                nxt_state = bmx_pkg::ST_WAIT;
                nxt_cnt = cnt_ff - bmx_pkg::CNT_LAST;
                nxt_wr_working = 1'b1;
                nxt_wr_addr = {bmx_pkg::WREG_PAD, wreg_rd_addr_ff};
                nxt_flags_out = flags_in;
                unique case (op_ff)
                    bmx_pkg::OP_BIT_SET: begin
                        nxt_wr_en = 1'b1;
                        nxt_wr_data = wreg_rd_data | mask;
                    end
                    bmx_pkg::OP_BIT_CLEAR: begin
                        nxt_wr_en = 1'b1;
                        nxt_wr_data = wreg_rd_data & ~mask;
                    end
                    bmx_pkg::OP_BIT_OR: begin
                        nxt_wr_en = 1'b1;
                        nxt_flag_we = 1'b1;
                        if (sel_ff) begin
                            // Register bit b takes its own value ORed with working bit zero
                            nxt_wr_working = 1'b0;
                            nxt_wr_addr = reg_rd_addr_ff;
                            nxt_wr_data = or_bit ? (reg_rd_data | mask)
                                : (reg_rd_data & ~mask);
                        end else begin
                            nxt_wr_data = {wreg_rd_data[7:1], or_bit};
                        end
                        // V is undefined; it is simply left as it was
                        nxt_flags_out[bmx_pkg::FLG_Z] = ~or_bit;
                        nxt_flags_out[bmx_pkg::FLG_S] = 1'b0;
                    end
                    bmx_pkg::OP_JUMP_ZERO: begin
                        // Base is the address past the three bytes
                        nxt_pc_we = ~tested;
                        nxt_pc_out = pcn_ff + disp_ext;
                    end
                    bmx_pkg::OP_JUMP_ONE: begin
                        nxt_pc_we = tested;
                        nxt_pc_out = pcn_ff + disp_ext;
                    end
                    default: begin
                        nxt_wr_en = 1'b0;
                    end
                endcase
            end
            bmx_pkg::ST_WAIT: begin
                // Pad out to the documented cycle count
                nxt_cnt = cnt_ff - bmx_pkg::CNT_LAST;
                if (cnt_ff == bmx_pkg::CNT_LAST) begin
                    nxt_state = bmx_pkg::ST_IDLE;
                    nxt_busy = 1'b0;
                    nxt_done = 1'b1;
                end
            end
            default: begin
                nxt_state = bmx_pkg::ST_IDLE;
                nxt_busy = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // Flag strobe never fires for set, clear or jumps
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_ff <= bmx_pkg::ST_IDLE;
            op_ff <= bmx_pkg::OP_NONE;
            cnt_ff <= 4'h0;
            bit_ff <= 3'h0;
            sel_ff <= 1'b0;
            disp_ff <= 8'h00;
            pcn_ff <= 16'h0000;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            illegal_ff <= 1'b0;
            wreg_rd_addr_ff <= 4'h0;
            reg_rd_addr_ff <= 8'h00;
            wr_en_ff <= 1'b0;
            wr_working_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            wr_data_ff <= 8'h00;
            flag_we_ff <= 1'b0;
            flags_out_ff <= 8'h00;
            pc_we_ff <= 1'b0;
            pc_out_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            op_ff <= nxt_op;
            cnt_ff <= nxt_cnt;
            bit_ff <= nxt_bit;
            sel_ff <= nxt_sel;
            disp_ff <= nxt_disp;
            pcn_ff <= nxt_pcn;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            illegal_ff <= nxt_illegal;
            wreg_rd_addr_ff <= nxt_wreg_rd_addr;
            reg_rd_addr_ff <= nxt_reg_rd_addr;
            wr_en_ff <= nxt_wr_en;
            wr_working_ff <= nxt_wr_working;
            wr_addr_ff <= nxt_wr_addr;
            wr_data_ff <= nxt_wr_data;
            flag_we_ff <= nxt_flag_we;
            flags_out_ff <= nxt_flags_out;
            pc_we_ff <= nxt_pc_we;
            pc_out_ff <= nxt_pc_out;
        end
    end

endmodule : bmx_exec

// File: bench/bmx_exec_checker.sv
// Port-level assertions for the bit manipulation execute unit.
// Assumes start is cycle 0 and outputs are sampled one edge after they show.
`timescale 1ns/1ps
module bmx_exec_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic [7:0] opcode,
    input wire logic [7:0] byte2,
    input wire logic [7:0] byte3,
    input wire logic [15:0] pc_next,
    input wire logic [7:0] flags_in,
    input wire logic [7:0] wreg_rd_data,
    input wire logic busy_ff,
    input wire logic done_ff,
    input wire logic wr_en_ff,
    input wire logic wr_working_ff,
    input wire logic [7:0] wr_addr_ff,
    input wire logic [7:0] wr_data_ff,
    input wire logic flag_we_ff,
    input wire logic [7:0] flags_out_ff,
    input wire logic pc_we_ff,
    input wire logic [15:0] pc_out_ff
);
    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Accepted instruction: start is ignored while busy
    sequence s_take(logic [7:0] op);
        start && !busy_ff && opcode == op;
    endsequence
    sequence s_end;
        done_ff && !busy_ff;
    endsequence

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_set_len;
        s_take(bmx_pkg::OPC_BIT_SET_CLR) |=> busy_ff [*2] ##1 s_end;
    endproperty
    a_set_len: assert property (p_set_len) else $error("bit set length wrong");
    property p_or_len;
        s_take(bmx_pkg::OPC_BIT_OR) |=> busy_ff [*4] ##1 s_end;
    endproperty
    a_or_len: assert property (p_or_len) else $error("bit or length wrong");
    property p_jmp_len;
        s_take(bmx_pkg::OPC_BIT_TEST) |=> busy_ff [*8] ##1 s_end;
    endproperty
    a_jmp_len: assert property (p_jmp_len) else $error("bit jump length wrong");
    property p_set_data;
        s_take(bmx_pkg::OPC_BIT_SET_CLR) ##0 byte2[0] |=> ##1 wr_en_ff && wr_working_ff
            && wr_data_ff == ($past(wreg_rd_data) | (8'h01 << $past(byte2[3:1], 2)))
            && wr_addr_ff == {4'h0, $past(byte2[7:4], 2)};
    endproperty
    a_set_data: assert property (p_set_data) else $error("bit set data wrong");
    property p_clr_data;
        s_take(bmx_pkg::OPC_BIT_SET_CLR) ##0 !byte2[0] |=> ##1 wr_en_ff
            && wr_data_ff == ($past(wreg_rd_data) & ~(8'h01 << $past(byte2[3:1], 2)));
    endproperty
    a_clr_data: assert property (p_clr_data) else $error("bit clear data wrong");
    // Set, clear and both jumps never load the flag byte
    property p_keep_flags;
        start && !busy_ff && (opcode == bmx_pkg::OPC_BIT_SET_CLR
            || opcode == bmx_pkg::OPC_BIT_TEST) |=> ##1 !flag_we_ff;
    endproperty
    a_keep_flags: assert property (p_keep_flags) else $error("flags touched");
    // Z follows the result bit, wherever the direction put it
    property p_or_flags;
        s_take(bmx_pkg::OPC_BIT_OR) |=> ##1 flag_we_ff && !flags_out_ff[bmx_pkg::FLG_S]
            && (flags_out_ff & 8'h8c) == ($past(flags_in) & 8'h8c)
            && flags_out_ff[bmx_pkg::FLG_Z] == (((wr_data_ff >> ($past(byte2[0], 2)
            ? $past(byte2[3:1], 2) : 3'h0)) & 8'h01) == 8'h00);
    endproperty
    a_or_flags: assert property (p_or_flags) else $error("bit or flags wrong");
    property p_jmp_target;
        s_take(bmx_pkg::OPC_BIT_TEST) |=> ##1
            pc_out_ff == $past(pc_next, 2) + 16'($signed($past(byte3, 2)));
    endproperty
    a_jmp_target: assert property (p_jmp_target) else $error("jump target wrong");
    property p_jmp_taken;
        s_take(bmx_pkg::OPC_BIT_TEST) |=> ##1 pc_we_ff == ((($past(wreg_rd_data)
            >> $past(byte2[3:1], 2)) & 8'h01) == {7'h0, $past(byte2[0], 2)});
    endproperty
    a_jmp_taken: assert property (p_jmp_taken) else $error("jump decision wrong");
endmodule : bmx_exec_checker

bind bmx_exec bmx_exec_checker u_chk (.clk(clk), .nrst(nrst), .start(start),
    .opcode(opcode), .byte2(byte2), .byte3(byte3), .pc_next(pc_next),
    .flags_in(flags_in), .wreg_rd_data(wreg_rd_data), .busy_ff(busy_ff),
    .done_ff(done_ff), .wr_en_ff(wr_en_ff), .wr_working_ff(wr_working_ff),
    .wr_addr_ff(wr_addr_ff), .wr_data_ff(wr_data_ff), .flag_we_ff(flag_we_ff),
    .flags_out_ff(flags_out_ff), .pc_we_ff(pc_we_ff), .pc_out_ff(pc_out_ff));

// File: bench/bmx_exec_test.sv
// Directed testbench of the bit manipulation execute unit.
// Assumes register read data is held from the start cycle to done.
`timescale 1ns/1ps
module bmx_exec_test;
    logic clk = 1'b0, nrst = 1'b0, start = 1'b0;
    logic [7:0] opcode = 8'h00, byte2 = 8'h00, byte3 = 8'h00, flags_in = 8'h00;
    logic [7:0] wreg_rd_data = 8'h00, reg_rd_data = 8'h00;
    logic [15:0] pc_next = 16'h0000;
    logic busy_ff, done_ff, illegal_ff, wr_en_ff, wr_working_ff, flag_we_ff, pc_we_ff;
    logic [3:0] wreg_rd_addr_ff;
    logic [7:0] reg_rd_addr_ff, wr_addr_ff, wr_data_ff, flags_out_ff;
    logic [15:0] pc_out_ff;
    logic s_wr, s_fl, s_pc, s_ill, g_work;
    logic [7:0] g_data, g_addr, g_flags;
    int fail_count = 0, checks_done = 0, wr_cyc, done_cyc;

    bmx_exec uut (.clk(clk), .nrst(nrst), .start(start), .opcode(opcode), .byte2(byte2),
        .byte3(byte3), .pc_next(pc_next), .flags_in(flags_in), .wreg_rd_data(wreg_rd_data),
        .reg_rd_data(reg_rd_data), .busy_ff(busy_ff), .done_ff(done_ff),
        .illegal_ff(illegal_ff), .wreg_rd_addr_ff(wreg_rd_addr_ff),
        .reg_rd_addr_ff(reg_rd_addr_ff), .wr_en_ff(wr_en_ff), .wr_working_ff(wr_working_ff),
        .wr_addr_ff(wr_addr_ff), .wr_data_ff(wr_data_ff), .flag_we_ff(flag_we_ff),
        .flags_out_ff(flags_out_ff), .pc_we_ff(pc_we_ff), .pc_out_ff(pc_out_ff));

    // 125 MHz clock
    always #4 clk = ~clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    // One instruction from a falling edge; poke retries start while busy
    task automatic run(input logic [7:0] opc, b2, b3, input logic [15:0] pcn,
                       input logic [7:0] wd, rd, fl, input bit poke);
        int n;
        n = 0;
        {start, opcode, byte2, byte3, pc_next} = {1'b1, opc, b2, b3, pcn};
        {wreg_rd_data, reg_rd_data, flags_in} = {wd, rd, fl};
        {s_wr, s_fl, s_pc, s_ill} = 4'h0;
        done_cyc = 0;
        wr_cyc = 0;
        while (done_cyc == 0 && n < 20) begin
            @(negedge clk);
            n++;
            start = poke && n == 1;
            if (start) opcode = 8'hff;
            if (illegal_ff === 1'b1) s_ill = 1'b1;
            if (pc_we_ff === 1'b1) s_pc = 1'b1;
            if (flag_we_ff === 1'b1) {s_fl, g_flags} = {1'b1, flags_out_ff};
            if (wr_en_ff === 1'b1) begin
                {s_wr, g_data, g_addr, g_work} = {1'b1, wr_data_ff, wr_addr_ff, wr_working_ff};
                wr_cyc = n;
            end
            if (done_ff === 1'b1) done_cyc = n;
        end
    endtask : run

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Every bit index, clear then set, other bits held at one
    task automatic t_set_clear;
        logic [7:0] m;
        for (int b = 0; b < 8; b++) begin
            m = 8'h01 << b;
            for (int s = 0; s < 2; s++) begin
                run(8'h77, {1'b1, b[2:0], b[2:0], s[0]}, 8'h00, 16'h0000,
                    s[0] ? ~m : 8'hff, 8'h00, 8'h00, 1'b0);
                // XOR keeps the upper byte clear once widened to the compare width
                check_val("bit data", s[0] ? 8'hff : m ^ 8'hff, g_data);
                check_val("bit read addr", {1'b1, b[2:0]}, wreg_rd_addr_ff);
                check_val("bit addr", {4'h1, b[2:0], 1'b1}, {g_addr, g_work});
                check_val("bit strobes", 3'b100, {s_wr, s_fl, s_pc});
                check_val("bit cycles", 16'h0203, {wr_cyc[7:0], done_cyc[7:0]});
            end
        end
    endtask : t_set_clear

    // Both directions, result bit zero and one
    task automatic t_or;
        logic [7:0] b2 [4] = '{8'h12, 8'h12, 8'h15, 8'h15};
        logic [7:0] wd [4] = '{8'h06, 8'h06, 8'h07, 8'h06};
        logic [7:0] rd [4] = '{8'h05, 8'h03, 8'h03, 8'h03};
        logic [7:0] fl [4] = '{8'hff, 8'h00, 8'h00, 8'h20};
        logic [7:0] ed [4] = '{8'h06, 8'h07, 8'h07, 8'h03};
        logic [7:0] ef [4] = '{8'hdf, 8'h00, 8'h00, 8'h40};
        for (int i = 0; i < 4; i++) begin
            run(8'h07, b2[i], 8'h01, 16'h0000, wd[i], rd[i], fl[i], 1'b0);
            check_val("or data", ed[i], g_data);
            check_val("or target", {8'h01, ~b2[i][0]}, {g_addr, g_work});
            check_val("or read addr", 8'h01, reg_rd_addr_ff);
            check_val("or flags", ef[i], g_flags);
            check_val("or cycles", 16'h0205, {wr_cyc[7:0], done_cyc[7:0]});
            check_val("or strobes", 2'b10, {s_fl, s_pc});
        end
    endtask : t_or

    // Jump on zero and on one, taken and not, both ends of the displacement
    task automatic t_jump;
        logic [7:0] b2 [5] = '{8'h16, 8'h16, 8'h17, 8'h17, 8'h70};
        logic [7:0] wd [5] = '{8'h07, 8'h0f, 8'h0f, 8'h07, 8'hfe};
        logic [7:0] dp [5] = '{8'hfe, 8'hfe, 8'h7f, 8'h80, 8'h80};
        logic [15:0] pc [5] = '{16'h0103, 16'h0103, 16'h0103, 16'h0103, 16'hfff0};
        logic [15:0] tg [5] = '{16'h0101, 16'h0101, 16'h0182, 16'h0083, 16'hff70};
        logic tk [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 5; i++) begin
            run(8'h37, b2[i], dp[i], pc[i], wd[i], 8'h00, 8'h5a, 1'b0);
            check_val("jump taken", tk[i], s_pc);
            check_val("jump target", tg[i], pc_out_ff);
            check_val("jump flags", 1'b0, s_fl);
            check_val("jump cycles", 16'h0009, done_cyc[15:0]);
        end
    endtask : t_jump

    // Unknown opcode, then a start refused while busy
    task automatic t_illegal;
        run(8'h17, 8'h13, 8'h00, 16'h0000, 8'h07, 8'h00, 8'h00, 1'b0);
        check_val("unknown op", 3'b100, {s_ill, s_wr, done_cyc != 0});
        run(8'h77, 8'h17, 8'h00, 16'h0000, 8'h07, 8'h00, 8'h00, 1'b1);
        check_val("busy start", 1'b0, s_ill);
        check_val("set walk", 8'h0f, g_data);
        check_val("set done", 16'h0003, done_cyc[15:0]);
    endtask : t_illegal

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        t_set_clear();
        t_or();
        t_jump();
        t_illegal();
        report_and_stop();
    end

    // Runs take about 140 cycles; this span of 1000 cycles leaves ample margin
    initial begin
        #8000;
        fail_count++;
        report_and_stop();
    end
endmodule : bmx_exec_test
